// ### hdl/ssc_pkg.sv
// Purpose : Shared constants and types for the scale slot command/status block
// Assumes : Four message slots, 16-bit words, one core clock
// Notes   : Bit positions of the status and command words live here
package ssc_pkg;
   localparam int NUM_SLOTS = 4;
   localparam int WORD_W    = 16;

   // Status word bit positions
   localparam int ST_TGT_LO   = 0;
   localparam int ST_CMP_LO   = 3;
   localparam int ST_ENTER    = 8;
   localparam int ST_IN_LO    = 9;
   localparam int ST_MOTION   = 12;
   localparam int ST_NET      = 13;
   localparam int ST_UPDATE   = 14;
   localparam int ST_DATA_OK  = 15;

   // Command word bit positions
   localparam int CM_SEL_LO     = 0;
   localparam int CM_LOAD_TARE  = 3;
   localparam int CM_CLR_TARE   = 4;
   localparam int CM_TARE       = 5;
   localparam int CM_PRINT      = 6;
   localparam int CM_ZERO       = 7;
   localparam int CM_TGT_RUN    = 8;
   localparam int CM_MSG_LO     = 9;
   localparam int CM_OUT_LO     = 12;
   localparam int CM_LOAD_TGT   = 15;

   // Message codes
   localparam logic [2:0] MSG_NONE   = 3'h0;
   localparam logic [2:0] MSG_TEXT_5 = 3'h5;
   localparam logic [2:0] MSG_PROMPT = 3'h6;
   localparam logic [2:0] MSG_NUMBER = 3'h7;

   // Reset values
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [2:0]  CODE_RST = 3'h0;

   // Select codes
   typedef enum logic [2:0] {
      SSC_SEL_GROSS = 3'h0,
      SSC_SEL_NET   = 3'h1,
      SSC_SEL_DISP  = 3'h2,
      SSC_SEL_TARE  = 3'h3,
      SSC_SEL_TGT   = 3'h4,
      SSC_SEL_RATE  = 3'h5
   } ssc_sel_t;
endpackage

// ### hdl/ssc_slot_if.sv
// Purpose : Carries one slot's value selection between top and slot formatter
// Assumes : Single core clock
// Notes   : Source values are shared by all slots
`timescale 1ns/1ps
`default_nettype none
interface ssc_slot_if;
   logic [15:0] cmd_word;
   logic [15:0] gross;
   logic [15:0] net;
   logic [15:0] disp;
   logic [15:0] tare;
   logic [15:0] target;
   logic [15:0] rate;
   logic        data_ok;
   logic [15:0] value;
   modport top (output cmd_word, gross, net, disp, tare, target, rate, data_ok,
                input value);
   modport fmt (input cmd_word, gross, net, disp, tare, target, rate, data_ok,
                output value);
endinterface
`default_nettype wire

// ### hdl/ssc_slot_fmt.sv
// Purpose : Chooses and registers the value word of one message slot
// Assumes : Select field taken from the slot's own command word
// Notes   : Value forced to zero whenever data is not valid
`timescale 1ns/1ps
`default_nettype none
module ssc_slot_fmt (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Slot carrier
   ssc_slot_if.fmt   sif
);
   logic [15:0] value_reg;
   logic [15:0] value_next;
   logic [2:0]  sel;

   assign sel = sif.cmd_word[ssc_pkg::CM_SEL_LO +: 3];

   // RULE14: select decode
   always_comb begin
      value_next = sif.gross;
      case (sel)
         ssc_pkg::SSC_SEL_NET:  value_next = sif.net;
         ssc_pkg::SSC_SEL_DISP: value_next = sif.disp;
         ssc_pkg::SSC_SEL_TARE: value_next = sif.tare;
         ssc_pkg::SSC_SEL_TGT:  value_next = sif.target;
         ssc_pkg::SSC_SEL_RATE: value_next = sif.rate;
         default:               value_next = sif.gross;
      endcase
      // RULE11: zero when invalid
      if (!sif.data_ok) begin
         value_next = ssc_pkg::WORD_RST;
      end
   end

   // RULE3: signed value word
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         value_reg <= ssc_pkg::WORD_RST;
      end else begin
         value_reg <= value_next;
      end
   end

   assign sif.value = value_reg;

   property p_sel_rate;
      @(posedge core_clk) disable iff (!rst_n)
      (sif.data_ok && sel == 3'h5) |=> value_reg == $past(sif.rate);
   endproperty
   a_sel_rate: assert property (p_sel_rate) else $error("rate select not reported"); // RULE14

   property p_zero_bad;
      @(posedge core_clk) disable iff (!rst_n)
      !sif.data_ok |=> value_reg == 16'h0000;
   endproperty
   a_zero_bad: assert property (p_zero_bad) else $error("value not zero while data invalid"); // RULE11
endmodule
`default_nettype wire

// ### hdl/ssc_core.sv
// Purpose : Slot exchange of a weighing terminal with a controller, integer format
// Assumes : Controller command words are sampled on an update strobe from the controller
// Notes   : Weight values and scale flags come from the weighing core on core_clk
//
// Summary of operation
// RULE1: each slot sends value and status words, receives value and command words
// RULE2: up to four slots; active count set by local configuration
// RULE3: first input word is signed 16-bit data picked by select field
// RULE4: status bits 0-2 show the target logic outputs
// RULE5: comparator status bits are 1 while the comparator is on
// RULE6: enter bit sets on key press, clears on message field change
// RULE7: status bits 9-11 mirror the three hardware inputs
// RULE8: status bit 12 is 1 while scale is in motion
// RULE9: status bit 13 is 1 while scale is in net mode
// RULE10: status bit 14 is 1 while slot data is refreshed
// RULE11: bit 15 normal; value forced to zero when data not valid
// RULE12: controller value word is a signed tare or target count
// RULE13: controller loads value word before raising load bits
// RULE14: select code 0-5 picks source; above 5 reports gross
// RULE15: rising bit 3 loads tare from value word, enters net
// RULE16: rising bit 4 zeroes tare store and enters gross
// RULE17: rising bit 5 tares present weight unless in motion
// RULE18: rising bit 6 requests print; rising bit 7 re-zeroes within range
// RULE19: bit 8 rising starts target logic, falling aborts it
// RULE20: message field leaving 0 records code and clears enter bit
// RULE21: message field must return to 0 before next code is taken
// RULE22: bits 12-14 drive free hardware outputs, never those locally owned
// RULE23: rising bit 15 loads target store from value word
// RULE24: bits 3-15 act only in slot 1; select works in all
// RULE25: edges found by comparing with previous update's command word
`timescale 1ns/1ps
`default_nettype none
module ssc_core (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Controller side, words packed slot 0 in low bits
   input  wire logic        upd_strobe,
   input  wire logic [63:0] ctl_value_words,
   input  wire logic [63:0] ctl_cmd_words,
   output logic      [63:0] dev_value_words,
   output logic      [63:0] dev_status_words,
   output logic      [3:0]  slot_active,
   // Configuration
   input  wire logic [2:0]  cfg_slot_count,
   input  wire logic [2:0]  cfg_out_local,
   // Weighing core values
   input  wire logic [15:0] gross_wt,
   input  wire logic [15:0] net_wt,
   input  wire logic [15:0] disp_wt,
   input  wire logic [15:0] rate_val,
   input  wire logic        motion,
   input  wire logic        power_up,
   input  wire logic        in_setup,
   input  wire logic        over_cap,
   input  wire logic        under_zero,
   input  wire logic        x10_mode,
   input  wire logic        zero_in_range,
   // Target, comparator, key and discrete pins
   input  wire logic [2:0]  target_state,
   input  wire logic [4:0]  comp_state,
   input  wire logic        enter_key,
   input  wire logic [2:0]  hw_in,
   input  wire logic [2:0]  out_local_val,
   output logic      [2:0]  hw_out,
   // Actions toward the weighing core
   output logic      [15:0] tare_store,
   output logic      [15:0] target_store,
   output logic             net_mode,
   output logic             tare_req,
   output logic             print_req,
   output logic             zero_req,
   output logic             target_start,
   output logic             target_abort,
   output logic      [2:0]  message_event_code,
   output logic             message_show,
   output logic             prompt_sequence_trigger
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Three stages; a change is accepted once stages two and three agree
   logic [2:0] in_s1;
   logic [2:0] in_s2;
   logic [2:0] in_s3;
   logic [2:0] in_reg;
   logic       key_s1;
   logic       key_s2;
   logic       key_s3;
   logic       key_reg;
   logic       key_prev_reg;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_s1   <= 3'h0;
         in_s2   <= 3'h0;
         in_s3   <= 3'h0;
         in_reg  <= 3'h0;
         key_s1  <= 1'b0;
         key_s2  <= 1'b0;
         key_s3  <= 1'b0;
         key_reg <= 1'b0;
      end else begin
         in_s1  <= hw_in;
         in_s2  <= in_s1;
         in_s3  <= in_s2;
         key_s1 <= enter_key;
         key_s2 <= key_s1;
         key_s3 <= key_s2;
         for (int i = 0; i < 3; i++) begin
            if (in_s2[i] == in_s3[i]) begin
               in_reg[i] <= in_s3[i];
            end
         end
         if (key_s2 == key_s3) begin
            key_reg <= key_s3;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         key_prev_reg <= 1'b0;
      end else begin
         key_prev_reg <= key_reg;
      end
   end

   // ----------------------------------------------------------------
   // Command edge detection
   // ----------------------------------------------------------------
   logic [15:0] cmd_prev_reg;
   logic [63:0] cmd_hold_reg;
   logic [15:0] cmd0;
   logic [15:0] rise;
   logic [15:0] fall;
   logic        take;

   assign cmd0 = ctl_cmd_words[15:0];
   assign take = upd_strobe;

   // RULE25: compare with previous update
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_prev_reg <= ssc_pkg::WORD_RST;
         cmd_hold_reg <= 64'h0000_0000_0000_0000;
      end else if (take) begin
         cmd_prev_reg <= cmd0;
         cmd_hold_reg <= ctl_cmd_words;
      end
   end

   // RULE24: only slot 1 commands act
   assign rise = take ? (cmd0 & ~cmd_prev_reg) : 16'h0000;
   assign fall = take ? (~cmd0 & cmd_prev_reg) : 16'h0000;

   // ----------------------------------------------------------------
   // Tare and target stores
   // ----------------------------------------------------------------
   // RULE12: value word is a signed division count
   // RULE13: value sampled together with the rising load bit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tare_store <= ssc_pkg::WORD_RST;
         net_mode   <= 1'b0;
      end else if (rise[ssc_pkg::CM_LOAD_TARE]) begin
         // RULE15: load tare, net mode
         tare_store <= ctl_value_words[15:0];
         net_mode   <= 1'b1;
      end else if (rise[ssc_pkg::CM_CLR_TARE]) begin
         // RULE16: clear tare, gross mode
         tare_store <= ssc_pkg::WORD_RST;
         net_mode   <= 1'b0;
      end else if (rise[ssc_pkg::CM_TARE] && !motion) begin
         // RULE17: tare only when stable
         tare_store <= gross_wt;
         net_mode   <= 1'b1;
      end
   end

   // RULE23: load target store
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         target_store <= ssc_pkg::WORD_RST;
      end else if (rise[ssc_pkg::CM_LOAD_TGT]) begin
         target_store <= ctl_value_words[15:0];
      end
   end

   // ----------------------------------------------------------------
   // One-cycle action pulses
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tare_req     <= 1'b0;
         print_req    <= 1'b0;
         zero_req     <= 1'b0;
         target_start <= 1'b0;
         target_abort <= 1'b0;
      end else begin
         // RULE17: motion blocks the tare
         tare_req     <= rise[ssc_pkg::CM_TARE] & ~motion;
         // RULE18: print and range-limited zero
         print_req    <= rise[ssc_pkg::CM_PRINT];
         zero_req     <= rise[ssc_pkg::CM_ZERO] & zero_in_range;
         // RULE19: start and abort
         target_start <= rise[ssc_pkg::CM_TGT_RUN];
         target_abort <= fall[ssc_pkg::CM_TGT_RUN];
      end
   end

   // ----------------------------------------------------------------
   // Message display and enter key
   // ----------------------------------------------------------------
   logic [2:0] msg_new;
   logic [2:0] msg_old;
   logic       msg_take;
   logic       msg_change;
   logic       enter_reg;

   assign msg_new    = cmd0[ssc_pkg::CM_MSG_LO +: 3];
   assign msg_old    = cmd_prev_reg[ssc_pkg::CM_MSG_LO +: 3];
   assign msg_change = take && (msg_new != msg_old);
   // RULE21: field must come from zero
   assign msg_take   = take && (msg_old == ssc_pkg::MSG_NONE)
                       && (msg_new != ssc_pkg::MSG_NONE);

   // RULE20: record code, prompt on six
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         message_event_code      <= ssc_pkg::CODE_RST;
         message_show            <= 1'b0;
         prompt_sequence_trigger <= 1'b0;
      end else begin
         message_show            <= msg_take;
         prompt_sequence_trigger <= msg_take && (msg_new == ssc_pkg::MSG_PROMPT);
         if (msg_take) begin
            message_event_code <= msg_new;
         end
      end
   end

   // RULE6: key press sets, field change clears; set wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         enter_reg <= 1'b0;
      end else if (key_reg && !key_prev_reg) begin
         enter_reg <= 1'b1;
      end else if (msg_change) begin
         enter_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Discrete outputs
   // ----------------------------------------------------------------
   logic [2:0] out_cmd_reg;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_cmd_reg <= 3'h0;
      end else if (take) begin
         out_cmd_reg <= cmd0[ssc_pkg::CM_OUT_LO +: 3];
      end
   end

   // RULE22: local ownership wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hw_out <= 3'h0;
      end else begin
         hw_out <= (cfg_out_local & out_local_val) | (~cfg_out_local & out_cmd_reg);
      end
   end

   // ----------------------------------------------------------------
   // Status words and slots
   // ----------------------------------------------------------------
   logic        data_ok;
   logic        upd_reg;
   logic [15:0] status_next;
   logic [63:0] val_all;

   // RULE11: validity
   assign data_ok = !(power_up || in_setup || over_cap || under_zero || x10_mode);

   // RULE10: busy during refresh cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         upd_reg <= 1'b1;
      end else begin
         upd_reg <= take;
      end
   end

   // RULE4: target bits
   // RULE5: comparator bits, comparator 1 in bit 7
   // RULE7: inputs
   // RULE8: motion
   // RULE9: net mode
   always_comb begin
      status_next = 16'h0000;
      status_next[ssc_pkg::ST_TGT_LO +: 3]  = target_state;
      for (int c = 0; c < 5; c++) begin
         status_next[ssc_pkg::ST_CMP_LO + 4 - c] = comp_state[c];
      end
      status_next[ssc_pkg::ST_ENTER]        = enter_reg;
      status_next[ssc_pkg::ST_IN_LO +: 3]   = in_reg;
      status_next[ssc_pkg::ST_MOTION]       = motion;
      status_next[ssc_pkg::ST_NET]          = net_mode;
      status_next[ssc_pkg::ST_UPDATE]       = upd_reg;
      status_next[ssc_pkg::ST_DATA_OK]      = data_ok;
   end

   // RULE2: slot count from configuration
   // RULE1: two words each direction per slot
   genvar s;
   generate
      for (s = 0; s < ssc_pkg::NUM_SLOTS; s++) begin : g_slot
         ssc_slot_if sif ();
         // Select held from the last update; words between updates are not valid
         assign sif.cmd_word = cmd_hold_reg[s*16 +: 16];
         assign sif.gross    = gross_wt;
         assign sif.net      = net_wt;
         assign sif.disp     = disp_wt;
         assign sif.tare     = tare_store;
         assign sif.target   = target_store;
         assign sif.rate     = rate_val;
         assign sif.data_ok  = data_ok;
         ssc_slot_fmt u_fmt (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .sif      (sif)
         );
         assign slot_active[s] = (3'(s) < cfg_slot_count);
         assign val_all[s*16 +: 16] = slot_active[s] ? sif.value : 16'h0000;
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               dev_status_words[s*16 +: 16] <= ssc_pkg::WORD_RST;
            end else begin
               dev_status_words[s*16 +: 16] <= slot_active[s] ? status_next : 16'h0000;
            end
         end
      end
   endgenerate

   assign dev_value_words = val_all;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_load_tare;
      @(posedge core_clk) disable iff (!rst_n)
      rise[3] |=> (tare_store == $past(ctl_value_words[15:0])) && net_mode;
   endproperty
   a_load_tare: assert property (p_load_tare) else $error("tare load failed"); // RULE15

   property p_clear_tare;
      @(posedge core_clk) disable iff (!rst_n)
      (rise[4] && !rise[3]) |=> tare_store == 16'h0000 && !net_mode;
   endproperty
   a_clear_tare: assert property (p_clear_tare) else $error("tare clear failed"); // RULE16

   property p_no_tare_motion;
      @(posedge core_clk) disable iff (!rst_n)
      motion |=> !tare_req;
   endproperty
   a_no_tare_motion: assert property (p_no_tare_motion) else $error("tare in motion"); // RULE17

   property p_abort;
      @(posedge core_clk) disable iff (!rst_n)
      $fell(cmd_prev_reg[8]) |-> target_abort;
   endproperty
   a_abort: assert property (p_abort) else $error("abort missing"); // RULE19

   property p_msg_zero_first;
      @(posedge core_clk) disable iff (!rst_n)
      message_show |-> $past(msg_old) == 3'h0;
   endproperty
   a_msg_zero_first: assert property (p_msg_zero_first) else $error("code taken from nonzero"); // RULE21

   property p_enter_clear;
      @(posedge core_clk) disable iff (!rst_n)
      (msg_change && !(key_reg && !key_prev_reg)) |=> !enter_reg;
   endproperty
   a_enter_clear: assert property (p_enter_clear) else $error("enter not cleared"); // RULE6

   property p_out_local;
      @(posedge core_clk) disable iff (!rst_n)
      cfg_out_local[0] |=> hw_out[0] == $past(out_local_val[0]);
   endproperty
   a_out_local: assert property (p_out_local) else $error("output override"); // RULE22

   property p_target_load;
      @(posedge core_clk) disable iff (!rst_n)
      rise[15] |=> target_store == $past(ctl_value_words[15:0]);
   endproperty
   a_target_load: assert property (p_target_load) else $error("target load failed"); // RULE23

   c_tare: cover property (@(posedge core_clk) disable iff (!rst_n) tare_req);
   c_msg:  cover property (@(posedge core_clk) disable iff (!rst_n) prompt_sequence_trigger);
   c_abort: cover property (@(posedge core_clk) disable iff (!rst_n) target_abort);
endmodule
`default_nettype wire

// ### bench/ssc_plc_model.sv
// Purpose : Controller model for the slot exchange, one update per strobe
// Assumes : One core clock; words change on the falling edge
// Notes   : Between strobes the words are scrambled, so stale sampling shows up
`timescale 1ns/1ps
`default_nettype none
module ssc_plc_model (
   // Clock
   input  wire logic        core_clk,
   // Controller words
   output logic             upd_strobe,
   output logic      [63:0] ctl_value_words,
   output logic      [63:0] ctl_cmd_words
);
   initial begin
      upd_strobe      = 1'b0;
      ctl_value_words = 64'h0000_0000_0000_0000;
      ctl_cmd_words   = 64'h0000_0000_0000_0000;
   end

   // value rides with its load bit
   task automatic xfer(input logic [63:0] val, input logic [63:0] cmd);
      @(negedge core_clk);
      upd_strobe      = 1'b1;
      ctl_value_words = val;
      ctl_cmd_words   = cmd;
      @(negedge core_clk);
      upd_strobe      = 1'b0;
      // Outside an update the words carry nothing valid
      ctl_value_words = ~val;
      ctl_cmd_words   = ~cmd;
   endtask
endmodule
`default_nettype wire

// ### bench/scale_slot_integer_cmd_status_bench.sv
// Purpose : Self-checking bench for the slot command/status core
// Assumes : Controller model drives the words; bench drives the weighing side
// Notes   : Reference model kept in plain variables; one command edge per update
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module scale_slot_integer_cmd_status_bench;
   logic        core_clk, rst_n, upd_strobe, motion, power_up, in_setup, over_cap;
   logic        under_zero, x10_mode, zero_in_range, enter_key, net_mode;
   logic        tare_req, print_req, zero_req, target_start, target_abort;
   logic        message_show, prompt_sequence_trigger;
   logic [63:0] ctl_value_words, ctl_cmd_words, dev_value_words, dev_status_words;
   logic [15:0] gross_wt, net_wt, disp_wt, rate_val, tare_store, target_store;
   logic [2:0]  cfg_slot_count, cfg_out_local, target_state, hw_in, out_local_val;
   logic [2:0]  hw_out, message_event_code;
   logic [4:0]  comp_state;
   logic [3:0]  slot_active;
   logic [6:0]  pulses;
   logic [7:0]  cnt [7];
   logic [7:0]  upd_cnt;
   logic [15:0] m_tare, m_tgt, prev;
   logic [63:0] last_cmd;
   logic [31:0] seed;
   logic [2:0]  m_code;
   logic        m_net, m_enter;
   int          err_total, check_count, cyc;

   ssc_plc_model plc (.core_clk(core_clk), .upd_strobe(upd_strobe),
      .ctl_value_words(ctl_value_words), .ctl_cmd_words(ctl_cmd_words));

   ssc_core DUT (.core_clk(core_clk), .rst_n(rst_n), .upd_strobe(upd_strobe),
      .ctl_value_words(ctl_value_words), .ctl_cmd_words(ctl_cmd_words),
      .dev_value_words(dev_value_words), .dev_status_words(dev_status_words),
      .slot_active(slot_active), .cfg_slot_count(cfg_slot_count),
      .cfg_out_local(cfg_out_local), .gross_wt(gross_wt), .net_wt(net_wt),
      .disp_wt(disp_wt), .rate_val(rate_val), .motion(motion), .power_up(power_up),
      .in_setup(in_setup), .over_cap(over_cap), .under_zero(under_zero),
      .x10_mode(x10_mode), .zero_in_range(zero_in_range), .target_state(target_state),
      .comp_state(comp_state), .enter_key(enter_key), .hw_in(hw_in),
      .out_local_val(out_local_val), .hw_out(hw_out), .tare_store(tare_store),
      .target_store(target_store), .net_mode(net_mode), .tare_req(tare_req),
      .print_req(print_req), .zero_req(zero_req), .target_start(target_start),
      .target_abort(target_abort), .message_event_code(message_event_code),
      .message_show(message_show), .prompt_sequence_trigger(prompt_sequence_trigger));

   assign pulses = {tare_req, print_req, zero_req, target_start, target_abort,
                    message_show, prompt_sequence_trigger};

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // Pulse counting and hang guard
   // ------------------------------------------------------------
   always @(negedge core_clk) begin
      if (rst_n) begin
         for (int i = 0; i < 7; i++) cnt[i] += {7'h00, pulses[i]};
         upd_cnt += {7'h00, dev_status_words[ssc_pkg::ST_UPDATE]};
      end
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check_words;
      logic [15:0] src;
      logic [15:0] st;
      logic        ok;
      logic        act;
      ok = !(power_up | in_setup | over_cap | under_zero | x10_mode);
      st = {ok, 1'b0, m_net, motion, hw_in, m_enter, comp_state[0], comp_state[1],
            comp_state[2], comp_state[3], comp_state[4], target_state};
      for (int s = 0; s < 4; s++) begin
         case (last_cmd[16*s +: 3])
            3'h1: src = net_wt;
            3'h2: src = disp_wt;
            3'h3: src = m_tare;
            3'h4: src = m_tgt;
            3'h5: src = rate_val;
            default: src = gross_wt;
         endcase
         act = (s < int'(cfg_slot_count));
         `CHK(slot_active[s], act)
         `CHK(dev_value_words[16*s +: 16], (act && ok) ? src : 16'h0000)
         `CHK(dev_status_words[16*s +: 16], act ? st : 16'h0000)
      end
      `CHK(hw_out, (cfg_out_local & out_local_val) | (~cfg_out_local & prev[14:12]))
      `CHK(tare_store, m_tare)
      `CHK(net_mode, m_net)
      `CHK(target_store, m_tgt)
      `CHK(message_event_code, m_code)
   endtask

   // One update: model the edges, send, let it settle, compare
   task automatic step(input logic [63:0] val, input logic [63:0] cmd);
      logic [15:0] r;
      logic [15:0] f;
      logic [6:0]  e;
      r = cmd[15:0] & ~prev;
      f = ~cmd[15:0] & prev;
      if (r[ssc_pkg::CM_LOAD_TARE]) begin
         m_tare = val[15:0];
         m_net  = 1'b1;
      end else if (r[ssc_pkg::CM_CLR_TARE]) begin
         m_tare = 16'h0000;
         m_net  = 1'b0;
      end else if (r[ssc_pkg::CM_TARE] && !motion) begin
         m_tare = gross_wt;
         m_net  = 1'b1;
      end
      if (r[ssc_pkg::CM_LOAD_TGT]) m_tgt = val[15:0];
      if (cmd[11:9] != prev[11:9]) m_enter = 1'b0;
      e[6] = r[5] & !motion;
      e[5] = r[6];
      e[4] = r[7] & zero_in_range;
      e[3] = r[8];
      e[2] = f[8];
      e[1] = (prev[11:9] == 3'h0) && (cmd[11:9] != 3'h0);
      e[0] = e[1] && (cmd[11:9] == ssc_pkg::MSG_PROMPT);
      if (e[1]) m_code = cmd[11:9];
      prev     = cmd[15:0];
      last_cmd = cmd;
      for (int i = 0; i < 7; i++) cnt[i] = 8'h00;
      upd_cnt = 8'h00;
      plc.xfer(val, cmd);
      repeat (6) @(negedge core_clk);
      for (int i = 0; i < 7; i++) `CHK(cnt[i], {7'h00, e[i]})
      `CHK(upd_cnt, 8'h01)
      check_words();
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [63:0] c;
      int          k;
      seed = 32'hd74f_e935;
      {rst_n, motion, power_up, in_setup, over_cap, under_zero, x10_mode} = 7'h00;
      {zero_in_range, enter_key, gross_wt, net_wt, disp_wt, rate_val} = 66'h0;
      {cfg_out_local, target_state, hw_in, out_local_val, comp_state} = 17'h0_0000;
      cfg_slot_count = 3'h4;
      {m_tare, m_tgt, prev, last_cmd, m_code, m_net, m_enter} = 117'h0;
      repeat (20) @(negedge core_clk);
      `CHK(dev_status_words, 64'h0000_0000_0000_0000)
      `CHK(hw_out, 3'h0)
      rst_n = 1'b1;
      // Let the busy bit shown after reset pass before the first update
      repeat (2) @(negedge core_clk);
      for (int n = 0; n < 400; n++) begin
         r = xs();
         gross_wt = r[15:0];
         net_wt   = r[31:16];
         r = xs();
         disp_wt  = r[15:0];
         rate_val = r[31:16];
         r = xs();
         {zero_in_range, motion} = r[1:0];
         {power_up, in_setup, over_cap, under_zero, x10_mode} = r[6:2] & {5{r[9:7] == 3'h0}};
         {target_state, comp_state, hw_in} = r[20:10];
         {cfg_out_local, out_local_val} = r[26:21];
         cfg_slot_count = {1'b0, r[28:27]} + 3'h1;
         // one command bit (3-15) of slot 0 flips and its select bits are random; other slots carry noise
         c = {xs(), xs()};
         r = xs();
         k = 3 + int'(r[31:28]) % 13;
         c[15:0] = prev ^ (16'h0001 << k);
         c[2:0]  = r[2:0];
         step({xs(), xs()}, c);
      end
      // key press sets the enter bit, a message field change clears it
      enter_key = 1'b1;
      repeat (8) @(negedge core_clk);
      m_enter = 1'b1;
      check_words();
      enter_key = 1'b0;
      step(64'h0000_0000_0000_1234, {48'h0, prev ^ 16'h0200});
      results();
   end
endmodule
`default_nettype wire
